// [csf_pkg.sv]
/*
  Shared constants and types for the CPU status flag logic.
  Assumes one core clock and one asynchronous active-high reset.
*/
// Functional notes
// - Eight-bit flags, upper four testable by jumps
// - Flag update colliding with flags write: undefined
// - Logic ops update flags; loads leave them
// - Overflow bit 4 on signed range exceed
// - Logic operations always clear overflow
// - Sign bit 5 copies result MSB
// - Zero bit 6 set on all-zero result
// - Carry bit 7 on carry/borrow at MSB
// - Rotate/shift carry takes last bit out
// - Set, clear and complement carry instructions
// - Flags mapped at register address D5h
// - Working 0-15, registers 0-255, pairs even
// - Relative target: signed offset plus next PC
// - Direct and long addresses span 0-8191
// - Interrupt pushes PC low, high, flags
package csf_pkg;

  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [7:0] CSF_FLAGS_ADDR = 8'hD5;
  localparam logic [7:0] CSF_FLAGS_RST = 8'h00;
  localparam int CSF_BIT_V = 4;
  localparam int CSF_BIT_S = 5;
  localparam int CSF_BIT_Z = 6;
  localparam int CSF_BIT_C = 7;
  localparam int CSF_PC_W = 13;
  localparam int CSF_SMAX = 127;
  localparam int CSF_SMIN = -128;
  localparam logic [2:0] CSF_DA_HIGH_ZERO = 3'h0;
  localparam logic [7:0] CSF_BYTE_ZERO = 8'h00;

  // ****************************************
  // Operation and sequencer types
  // ****************************************
  typedef enum logic [4:0] {
    CSF_OP_LOAD = 5'h00,
    CSF_OP_ADD = 5'h01,
    CSF_OP_ADC = 5'h02,
    CSF_OP_SUB = 5'h03,
    CSF_OP_SBC = 5'h04,
    CSF_OP_CP = 5'h05,
    CSF_OP_INC = 5'h06,
    CSF_OP_DEC = 5'h07,
    CSF_OP_AND = 5'h08,
    CSF_OP_OR = 5'h09,
    CSF_OP_XOR = 5'h0A,
    CSF_OP_COM = 5'h0B,
    CSF_OP_TM = 5'h0C,
    CSF_OP_TCM = 5'h0D,
    CSF_OP_RL = 5'h0E,
    CSF_OP_RLC = 5'h0F,
    CSF_OP_RR = 5'h10,
    CSF_OP_RRC = 5'h11,
    CSF_OP_SRA = 5'h12,
    CSF_OP_SCF = 5'h13,
    CSF_OP_RCF = 5'h14,
    CSF_OP_CCF = 5'h15
  } csf_op_t;

  typedef enum logic [7:0] {
    CSF_SQ_IDLE = 8'h01,
    CSF_SQ_PUSH_LO = 8'h02,
    CSF_SQ_PUSH_HI = 8'h04,
    CSF_SQ_PUSH_FL = 8'h08,
    CSF_SQ_POP_FL = 8'h10,
    CSF_SQ_POP_HI = 8'h20,
    CSF_SQ_POP_LO = 8'h40,
    CSF_SQ_POP_END = 8'h80
  } csf_seq_t;

endpackage : csf_pkg

// [csf_alu_if.sv]
/*
  Carrier between the flag unit and its result/flag generator.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface csf_alu_if;
  import csf_pkg::*;
  csf_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] res;
  logic cout;
  logic vout;
  logic updC;
  logic updZsv;
  logic isLogic;
  logic wrRes;

  modport core (output op, a, b, cin,
    input res, cout, vout, updC, updZsv, isLogic, wrRes);
  modport alu (input op, a, b, cin,
    output res, cout, vout, updC, updZsv, isLogic, wrRes);
endinterface : csf_alu_if
`default_nettype wire

// [csf_alu.sv]
/*
  Combinational result, carry and overflow generator.
  Assumes operands and carry-in are held stable by the flag unit.
*/
`timescale 1ns/10ps
`default_nettype none
module csf_alu
  import csf_pkg::*;
(
  csf_alu_if.alu bus
);

  // Add with carry-in, returns {overflow, carry, sum}
  function automatic logic [9:0] csfAdd(input logic [7:0] x,
      input logic [7:0] y, input logic ci);
    logic [8:0] s;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    csfAdd = {(x[7] == y[7]) && (s[7] != x[7]), s};
  endfunction : csfAdd

  logic [9:0] addR;
  logic [9:0] adcR;
  logic [9:0] subR;
  logic [9:0] sbcR;
  logic [9:0] incR;
  logic [9:0] decR;

  // Adders for the arithmetic group
  assign addR = csfAdd(bus.a, bus.b, 1'b0);
  assign adcR = csfAdd(bus.a, bus.b, bus.cin);
  assign subR = csfAdd(bus.a, ~bus.b, 1'b1);
  assign sbcR = csfAdd(bus.a, ~bus.b, ~bus.cin);
  assign incR = csfAdd(bus.a, 8'h01, 1'b0);
  assign decR = csfAdd(bus.a, 8'hFF, 1'b0);

  // Result, carry and overflow per operation
  always_comb begin
    bus.res = bus.b;
    bus.cout = bus.cin;
    bus.vout = 1'b0;
    bus.updC = 1'b0;
    bus.updZsv = 1'b1;
    bus.isLogic = 1'b0;
    bus.wrRes = 1'b1;
    case (bus.op)
      CSF_OP_LOAD: begin
        bus.updZsv = 1'b0;
      end
      CSF_OP_ADD: begin
        {bus.vout, bus.cout, bus.res} = addR;
        bus.updC = 1'b1;
      end
      CSF_OP_ADC: begin
        {bus.vout, bus.cout, bus.res} = adcR;
        bus.updC = 1'b1;
      end
      CSF_OP_SUB, CSF_OP_CP: begin
        {bus.vout, bus.res} = {subR[9], subR[7:0]};
        bus.cout = ~subR[8];
        bus.updC = 1'b1;
        bus.wrRes = (bus.op == CSF_OP_SUB);
      end
      CSF_OP_SBC: begin
        {bus.vout, bus.res} = {sbcR[9], sbcR[7:0]};
        bus.cout = ~sbcR[8];
        bus.updC = 1'b1;
      end
      CSF_OP_INC: {bus.vout, bus.res} = {incR[9], incR[7:0]};
      CSF_OP_DEC: {bus.vout, bus.res} = {decR[9], decR[7:0]};
      CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR, CSF_OP_COM,
      CSF_OP_TM, CSF_OP_TCM: begin
        bus.isLogic = 1'b1;
        bus.wrRes = !(bus.op == CSF_OP_TM || bus.op == CSF_OP_TCM);
        case (bus.op)
          CSF_OP_AND, CSF_OP_TM: bus.res = bus.a & bus.b;
          CSF_OP_OR: bus.res = bus.a | bus.b;
          CSF_OP_XOR: bus.res = bus.a ^ bus.b;
          CSF_OP_COM: bus.res = ~bus.a;
          default: bus.res = ~bus.a & bus.b;
        endcase
      end
      CSF_OP_RL, CSF_OP_RLC: begin
        bus.res = {bus.a[6:0],
          (bus.op == CSF_OP_RL) ? bus.a[7] : bus.cin};
        bus.cout = bus.a[7];
        bus.vout = bus.a[7] ^ bus.a[6];
        bus.updC = 1'b1;
      end
      CSF_OP_RR, CSF_OP_RRC, CSF_OP_SRA: begin
        case (bus.op)
          CSF_OP_RR: bus.res = {bus.a[0], bus.a[7:1]};
          CSF_OP_RRC: bus.res = {bus.cin, bus.a[7:1]};
          default: bus.res = {bus.a[7], bus.a[7:1]};
        endcase
        bus.cout = bus.a[0];
        // Sign change between operand and result, SRA keeps sign
        bus.vout = (bus.op == CSF_OP_SRA) ? 1'b0 : bus.a[7] ^ bus.res[7];
        bus.updC = 1'b1;
      end
      CSF_OP_SCF, CSF_OP_RCF, CSF_OP_CCF: begin
        bus.cout = (bus.op == CSF_OP_SCF) ? 1'b1 :
          (bus.op == CSF_OP_RCF) ? 1'b0 : ~bus.cin;
        bus.updC = 1'b1;
        bus.updZsv = 1'b0;
        bus.wrRes = 1'b0;
      end
      default: begin
        bus.updZsv = 1'b0;
        bus.wrRes = 1'b0;
      end
    endcase
  end

endmodule : csf_alu
`default_nettype wire

// [csf_flag_unit.sv]
/*
  Status flag unit: flag register, register-port access, operand and
  branch address decoding, interrupt save and restore of PC and flags.
  Assumes the register file and stack memory outside share mclk; stack
  reads return data on the cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module csf_flag_unit
  import csf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic opValid,
  input wire csf_op_t opCode,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  output logic opReady,
  output logic [7:0] result,
  output logic resultWrite,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdHit,
  output logic [7:0] flags,
  output logic [3:0] condFlags,
  output logic flagCollision,
  input wire logic [3:0] wkNum,
  input wire logic [7:0] opndReg,
  input wire logic [7:0] opndPair,
  output logic [7:0] opndRegAddr,
  output logic wkPairOk,
  output logic pairOk,
  input wire logic brValid,
  input wire logic [CSF_PC_W-1:0] nextPc,
  input wire logic [7:0] brOffset,
  output logic [CSF_PC_W-1:0] brTarget,
  input wire logic [15:0] daField,
  output logic [CSF_PC_W-1:0] daAddr,
  output logic daOk,
  input wire logic intAck,
  input wire logic iretReq,
  input wire logic [CSF_PC_W-1:0] pcIn,
  output logic stkWrEn,
  output logic [7:0] stkWrData,
  output logic stkRdEn,
  input wire logic [7:0] stkRdData,
  output logic [CSF_PC_W-1:0] pcRestore,
  output logic pcLoad,
  output logic seqBusy
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic isEven(input logic [7:0] v);
    isEven = ~v[0];
  endfunction : isEven

  function automatic logic [CSF_PC_W-1:0] relTarget(
      input logic [CSF_PC_W-1:0] pc, input logic [7:0] off);
    relTarget = pc + {{(CSF_PC_W-8){off[7]}}, off};
  endfunction : relTarget

  // ****************************************
  // Declarations
  // ****************************************
  csf_alu_if aluBus();
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] result_r;
  logic resultWrite_r;
  logic [7:0] regRdData_r;
  logic regRdHit_r;
  logic flagCollision_r;
  logic [7:0] opndRegAddr_r;
  logic wkPairOk_r;
  logic pairOk_r;
  logic [CSF_PC_W-1:0] brTarget_r;
  logic [CSF_PC_W-1:0] daAddr_r;
  logic daOk_r;
  csf_seq_t seq_r;
  csf_seq_t seq_nxt;
  logic [CSF_PC_W-1:0] pcHold_r;
  logic [7:0] stkData_r;
  logic [7:0] stkData_nxt;
  logic [7:0] pcHi_r;
  logic [CSF_PC_W-1:0] pcRestore_r;
  logic pcLoad_r;
  logic seqIdle;
  logic opTake;
  logic flagRegWr;
  logic zeroRes;
  logic [7:0] aluFlags;
  logic [7:0] pcHiByte;

  // ****************************************
  // Result and flag generation
  // ****************************************
  csf_alu uAlu (
    .bus(aluBus.alu)
  );

  // Operand drive and flag assembly
  assign aluBus.op = opCode;
  assign aluBus.a = opA;
  assign aluBus.b = opB;
  assign aluBus.cin = flags_r[CSF_BIT_C];
  assign seqIdle = (seq_r == CSF_SQ_IDLE);
  assign opTake = opValid && seqIdle;
  assign flagRegWr = regWrEn && (regAddr == CSF_FLAGS_ADDR);
  assign zeroRes = (aluBus.res == CSF_BYTE_ZERO);
  assign aluFlags = {aluBus.cout, zeroRes, aluBus.res[7],
    aluBus.vout && !aluBus.isLogic, flags_r[3:0]};

  // Next flags: register write, then operation, then restore; last wins
  always_comb begin
    flags_nxt = flags_r;
    if (flagRegWr) begin
      flags_nxt = regWrData;
    end
    if (opTake && aluBus.updZsv) begin
      flags_nxt[CSF_BIT_Z:CSF_BIT_V] = aluFlags[CSF_BIT_Z:CSF_BIT_V];
    end
    if (opTake && aluBus.updC) begin
      flags_nxt[CSF_BIT_C] = aluFlags[CSF_BIT_C];
    end
    if (seq_r == CSF_SQ_POP_HI) begin
      flags_nxt = stkRdData;
    end
  end

  // Flag register and result capture
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_r <= CSF_FLAGS_RST;
      result_r <= CSF_BYTE_ZERO;
      resultWrite_r <= 1'b0;
      flagCollision_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      result_r <= opTake ? aluBus.res : result_r;
      resultWrite_r <= opTake && aluBus.wrRes;
      flagCollision_r <= flagRegWr && opTake &&
        (aluBus.updC || aluBus.updZsv);
    end
  end

  // ****************************************
  // Register port read
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      regRdData_r <= CSF_BYTE_ZERO;
      regRdHit_r <= 1'b0;
    end else begin
      regRdHit_r <= regRdEn && (regAddr == CSF_FLAGS_ADDR);
      regRdData_r <= (regRdEn && regAddr == CSF_FLAGS_ADDR) ?
        flags_r : CSF_BYTE_ZERO;
    end
  end

  // ****************************************
  // Operand, branch and direct address decode
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      opndRegAddr_r <= CSF_BYTE_ZERO;
      wkPairOk_r <= 1'b0;
      pairOk_r <= 1'b0;
      brTarget_r <= '0;
      daAddr_r <= '0;
      daOk_r <= 1'b0;
    end else begin
      opndRegAddr_r <= opndReg;
      wkPairOk_r <= isEven({4'h0, wkNum});
      pairOk_r <= isEven(opndPair);
      if (brValid) begin
        brTarget_r <= relTarget(nextPc, brOffset);
      end
      daAddr_r <= daField[CSF_PC_W-1:0];
      daOk_r <= (daField[15:CSF_PC_W] == CSF_DA_HIGH_ZERO);
    end
  end

  // ****************************************
  // Interrupt save and restore sequencer
  // ****************************************
  assign pcHiByte = {{(16-CSF_PC_W){1'b0}}, pcHold_r[CSF_PC_W-1:8]};

  // Next state and next stacked byte
  always_comb begin
    seq_nxt = seq_r;
    stkData_nxt = stkData_r;
    case (seq_r)
      CSF_SQ_IDLE: begin
        if (intAck) begin
          seq_nxt = CSF_SQ_PUSH_LO;
          stkData_nxt = pcIn[7:0];
        end else if (iretReq) begin
          seq_nxt = CSF_SQ_POP_FL;
        end
      end
      CSF_SQ_PUSH_LO: begin
        seq_nxt = CSF_SQ_PUSH_HI;
        stkData_nxt = pcHiByte;
      end
      CSF_SQ_PUSH_HI: begin
        seq_nxt = CSF_SQ_PUSH_FL;
        stkData_nxt = flags_r;
      end
      CSF_SQ_PUSH_FL: seq_nxt = CSF_SQ_IDLE;
      CSF_SQ_POP_FL: seq_nxt = CSF_SQ_POP_HI;
      CSF_SQ_POP_HI: seq_nxt = CSF_SQ_POP_LO;
      CSF_SQ_POP_LO: seq_nxt = CSF_SQ_POP_END;
      CSF_SQ_POP_END: seq_nxt = CSF_SQ_IDLE;
      default: seq_nxt = CSF_SQ_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seq_r <= CSF_SQ_IDLE;
      stkData_r <= CSF_BYTE_ZERO;
      pcHold_r <= '0;
      pcHi_r <= CSF_BYTE_ZERO;
      pcRestore_r <= '0;
      pcLoad_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      stkData_r <= stkData_nxt;
      pcHold_r <= (seqIdle && intAck) ? pcIn : pcHold_r;
      pcHi_r <= (seq_r == CSF_SQ_POP_LO) ? stkRdData : pcHi_r;
      pcLoad_r <= (seq_r == CSF_SQ_POP_END);
      if (seq_r == CSF_SQ_POP_END) begin
        pcRestore_r <= {pcHi_r[CSF_PC_W-9:0], stkRdData};
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign opReady = seqIdle;
  assign result = result_r;
  assign resultWrite = resultWrite_r;
  assign regRdData = regRdData_r;
  assign regRdHit = regRdHit_r;
  assign flags = flags_r;
  assign condFlags = flags_r[CSF_BIT_C:CSF_BIT_V];
  assign flagCollision = flagCollision_r;
  assign opndRegAddr = opndRegAddr_r;
  assign wkPairOk = wkPairOk_r;
  assign pairOk = pairOk_r;
  assign brTarget = brTarget_r;
  assign daAddr = daAddr_r;
  assign daOk = daOk_r;
  assign stkWrEn = (seq_r == CSF_SQ_PUSH_LO) || (seq_r == CSF_SQ_PUSH_HI)
    || (seq_r == CSF_SQ_PUSH_FL);
  assign stkWrData = stkData_r;
  assign stkRdEn = (seq_r == CSF_SQ_POP_FL) || (seq_r == CSF_SQ_POP_HI)
    || (seq_r == CSF_SQ_POP_LO);
  assign pcRestore = pcRestore_r;
  assign pcLoad = pcLoad_r;
  assign seqBusy = !seqIdle;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  logic [8:0] chkSum;
  logic signed [9:0] chkSSum;
  logic chkPlain;
  assign chkSum = {1'b0, opA} + {1'b0, opB};
  assign chkSSum = $signed({opA[7], opA[7], opA}) +
    $signed({opB[7], opB[7], opB});
  assign chkPlain = opTake && !flagRegWr;

  sequence pushThree;
    stkWrEn && stkWrData == $past(pcIn[7:0]) ##1
    stkWrEn && stkWrData == pcHiByte ##1
    stkWrEn && stkWrData == flags_r;
  endsequence
  sequence popThree;
    stkRdEn[*3] ##1 !stkRdEn && pcLoad == 1'b0 ##1 pcLoad;
  endsequence

  chk_sign_copy: assert property (chkPlain && aluBus.updZsv
    |=> flags_r[CSF_BIT_S] == result_r[7])
    else $error("sign flag differs from result msb");
  chk_zero_set: assert property (chkPlain && aluBus.updZsv
    |=> flags_r[CSF_BIT_Z] == (result_r == CSF_BYTE_ZERO))
    else $error("zero flag wrong for result");
  chk_logic_vclear: assert property (chkPlain && aluBus.isLogic
    |=> !flags_r[CSF_BIT_V])
    else $error("overflow not cleared after logic op");
  chk_add_carry: assert property (chkPlain && opCode == CSF_OP_ADD
    |=> flags_r[CSF_BIT_C] == $past(chkSum[8]))
    else $error("add carry wrong");
  chk_add_ovf: assert property (chkPlain && opCode == CSF_OP_ADD
    |=> flags_r[CSF_BIT_V] == ($past(chkSSum) > CSF_SMAX ||
      $past(chkSSum) < CSF_SMIN))
    else $error("add overflow wrong");
  chk_rot_carry: assert property (chkPlain && opCode == CSF_OP_RL
    |=> flags_r[CSF_BIT_C] == $past(opA[7]))
    else $error("rotate carry is not the bit shifted out");
  chk_ccf_invert: assert property (chkPlain && opCode == CSF_OP_CCF
    |=> flags_r[CSF_BIT_C] != $past(flags_r[CSF_BIT_C]))
    else $error("carry not complemented");
  chk_load_keep: assert property (chkPlain && opCode == CSF_OP_LOAD
    |=> $stable(flags_r))
    else $error("load changed flags");
  chk_flags_read: assert property (regRdEn
    && regAddr == CSF_FLAGS_ADDR
    |=> regRdHit && regRdData == $past(flags_r))
    else $error("flags read mismatch");
  chk_branch_calc: assert property (brValid
    |=> brTarget == $past(nextPc) + {{(CSF_PC_W-8){$past(brOffset[7])}},
      $past(brOffset)})
    else $error("relative target wrong");
  chk_push_order: assert property (seqIdle && intAck
    |=> pushThree ##1 seqIdle)
    else $error("interrupt push order wrong");
  chk_pop_order: assert property (seqIdle && !intAck && iretReq
    |=> popThree)
    else $error("interrupt restore order wrong");

endmodule : csf_flag_unit
`default_nettype wire

// [csf_flag_unit_tb.sv]
/*
  Self-checking testbench for the CPU status flag unit.
  Assumes csf_pkg is compiled first; the bench plays the register file
  and the stack memory itself.
*/
`timescale 1ns/10ps
`default_nettype none
module csf_flag_unit_tb;
  import csf_pkg::*;
  // ********************************
  // Stimulus and observed signals
  // ********************************
  logic mclk, reset, opValid, opReady, resultWrite, regWrEn, regRdEn;
  logic regRdHit, flagCollision, wkPairOk, pairOk, brValid, daOk;
  logic intAck, iretReq, stkWrEn, stkRdEn, pcLoad, seqBusy;
  csf_op_t opCode;
  logic [7:0] opA, opB, result, regAddr, regWrData, regRdData, flags;
  logic [7:0] opndReg, opndPair, opndRegAddr, brOffset, stkWrData;
  logic [7:0] stkRdData;
  logic [3:0] condFlags, wkNum;
  logic [15:0] daField;
  logic [CSF_PC_W-1:0] nextPc, brTarget, daAddr, pcIn, pcRestore;
  int n_fail = 0;
  int num_checks = 0;

  csf_flag_unit dut (.mclk(mclk), .reset(reset), .opValid(opValid),
    .opCode(opCode), .opA(opA), .opB(opB), .opReady(opReady),
    .result(result), .resultWrite(resultWrite), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdHit(regRdHit), .flags(flags),
    .condFlags(condFlags), .flagCollision(flagCollision), .wkNum(wkNum),
    .opndReg(opndReg), .opndPair(opndPair), .opndRegAddr(opndRegAddr),
    .wkPairOk(wkPairOk), .pairOk(pairOk), .brValid(brValid),
    .nextPc(nextPc), .brOffset(brOffset), .brTarget(brTarget),
    .daField(daField), .daAddr(daAddr), .daOk(daOk), .intAck(intAck),
    .iretReq(iretReq), .pcIn(pcIn), .stkWrEn(stkWrEn),
    .stkWrData(stkWrData), .stkRdEn(stkRdEn), .stkRdData(stkRdData),
    .pcRestore(pcRestore), .pcLoad(pcLoad), .seqBusy(seqBusy));

  // ********************************
  // Clock, reporting and bus helpers
  // ********************************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One operation, sampled once it has landed
  task automatic doOp(input csf_op_t op, input logic [7:0] a, b);
    @(posedge mclk);
    opValid <= 1'b1;
    opCode <= op;
    opA <= a;
    opB <= b;
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask : doOp

  // Operation plus check of result and upper flag nibble
  task automatic opChk(input csf_op_t op, input logic [7:0] a, b, r,
      input logic [3:0] f);
    doOp(op, a, b);
    chk(result, r, "result");
    chk(flags[7:4], f, "flags");
    chk(condFlags, f, "cond flags");
  endtask : opChk

  task automatic wrReg(input logic [7:0] a, d);
    @(posedge mclk);
    regAddr <= a;
    regWrEn <= 1'b1;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
    #1;
  endtask : wrReg

  task automatic rdChk(input logic [7:0] a, d, input logic h);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, d, "read data");
    chk(regRdHit, h, "read hit");
  endtask : rdChk

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_arith;
    chk(flags, CSF_FLAGS_RST, "reset flags");
    chk(opReady, 1'b1, "reset ready");
    opChk(CSF_OP_ADD, 8'hFF, 8'h01, 8'h00, 4'hC);
    chk(resultWrite, 1'b1, "write pulse");
    opChk(CSF_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'h3);
    opChk(CSF_OP_SUB, 8'h00, 8'h01, 8'hFF, 4'hA);
    opChk(CSF_OP_SUB, 8'h80, 8'h01, 8'h7F, 4'h1);
    opChk(CSF_OP_SBC, 8'h05, 8'h01, 8'h04, 4'h0);
    opChk(CSF_OP_INC, 8'h7F, 8'h00, 8'h80, 4'h3);
    opChk(CSF_OP_SCF, 8'h00, 8'h00, 8'h00, 4'hB);
    opChk(CSF_OP_ADC, 8'h01, 8'h01, 8'h03, 4'h0);
    opChk(CSF_OP_DEC, 8'h01, 8'h00, 8'h00, 4'h4);
    opChk(CSF_OP_CP, 8'h05, 8'h06, 8'hFF, 4'hA);
    chk(resultWrite, 1'b0, "compare writes");
    $display("arith done");
  endtask : t_arith

  task automatic t_logic;
    opChk(CSF_OP_ADD, 8'h7F, 8'h01, 8'h80, 4'h3);
    opChk(CSF_OP_AND, 8'hFF, 8'h80, 8'h80, 4'h2);
    opChk(CSF_OP_OR, 8'h00, 8'h00, 8'h00, 4'h4);
    opChk(CSF_OP_LOAD, 8'h00, 8'h81, 8'h81, 4'h4);
    opChk(CSF_OP_XOR, 8'h5A, 8'hA5, 8'hFF, 4'h2);
    opChk(CSF_OP_COM, 8'hFF, 8'h00, 8'h00, 4'h4);
    opChk(CSF_OP_TM, 8'h0F, 8'hF0, 8'h00, 4'h4);
    opChk(CSF_OP_TCM, 8'h0F, 8'h0F, 8'h00, 4'h4);
    $display("logic done");
  endtask : t_logic

  task automatic t_rotate;
    opChk(CSF_OP_RCF, 8'h00, 8'h00, 8'h00, 4'h4);
    opChk(CSF_OP_RL, 8'h80, 8'h00, 8'h01, 4'h9);
    opChk(CSF_OP_RR, 8'h01, 8'h00, 8'h80, 4'hB);
    opChk(CSF_OP_RLC, 8'h00, 8'h00, 8'h01, 4'h0);
    opChk(CSF_OP_RRC, 8'h01, 8'h00, 8'h00, 4'hC);
    opChk(CSF_OP_SRA, 8'h81, 8'h00, 8'hC0, 4'hA);
    opChk(CSF_OP_CCF, 8'h00, 8'h00, 8'h00, 4'h2);
    opChk(CSF_OP_CCF, 8'h00, 8'h00, 8'h00, 4'hA);
    $display("rotate done");
  endtask : t_rotate

  task automatic t_regs;
    wrReg(CSF_FLAGS_ADDR, 8'hA5);
    chk(flags, 8'hA5, "flags write");
    chk(condFlags, 4'hA, "cond nibble");
    wrReg(8'hD6, 8'hFF);
    chk(flags, 8'hA5, "stray write");
    rdChk(CSF_FLAGS_ADDR, 8'hA5, 1'b1);
    rdChk(8'hD4, 8'h00, 1'b0);
    // Flag op and flags write in the same cycle
    @(posedge mclk);
    regAddr <= CSF_FLAGS_ADDR;
    regWrEn <= 1'b1;
    regWrData <= 8'h0F;
    opValid <= 1'b1;
    opCode <= CSF_OP_AND;
    opA <= 8'h00;
    opB <= 8'h00;
    @(posedge mclk);
    regWrEn <= 1'b0;
    opValid <= 1'b0;
    #1;
    chk(flagCollision, 1'b1, "collision");
    chk(flags, 8'h4F, "collision flags");
    $display("regs done");
  endtask : t_regs

  task automatic t_decode;
    @(posedge mclk);
    wkNum <= 4'hF;
    opndReg <= 8'hFF;
    opndPair <= 8'hFE;
    daField <= 16'h1FFF;
    brValid <= 1'b1;
    nextPc <= 13'h0010;
    brOffset <= 8'h80;
    @(posedge mclk);
    wkNum <= 4'hE;
    opndPair <= 8'h01;
    daField <= 16'h2000;
    nextPc <= 13'h1FF0;
    brOffset <= 8'h7F;
    #1;
    chk(opndRegAddr, 8'hFF, "reg addr");
    chk({wkPairOk, pairOk}, 2'h1, "pairs odd wk");
    chk({daOk, daAddr}, 14'h3FFF, "direct top");
    chk(brTarget, 13'h1F90, "branch back");
    @(posedge mclk);
    brValid <= 1'b0;
    #1;
    chk({wkPairOk, pairOk}, 2'h2, "pairs odd pair");
    chk(daOk, 1'b0, "direct over");
    chk(brTarget, 13'h006F, "branch fwd");
    $display("decode done");
  endtask : t_decode

  task automatic t_intr;
    wrReg(CSF_FLAGS_ADDR, 8'h16);
    @(posedge mclk);
    intAck <= 1'b1;
    pcIn <= 13'h1A5C;
    @(posedge mclk);
    intAck <= 1'b0;
    opValid <= 1'b1;
    opCode <= CSF_OP_SCF;
    #1;
    chk({stkWrEn, stkWrData}, 9'h15C, "push pc low");
    chk({opReady, seqBusy}, 2'h1, "busy");
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
    chk({stkWrEn, stkWrData}, 9'h11A, "push pc high");
    @(posedge mclk);
    #1;
    chk({stkWrEn, stkWrData}, 9'h116, "push flags");
    @(posedge mclk);
    #1;
    chk({stkWrEn, opReady}, 2'h1, "save end");
    chk(flags, 8'h16, "refused op");
    @(posedge mclk);
    iretReq <= 1'b1;
    @(posedge mclk);
    iretReq <= 1'b0;
    stkRdData <= 8'hE9;
    #1;
    chk(stkRdEn, 1'b1, "pop start");
    @(posedge mclk);
    stkRdData <= 8'h3C;
    @(posedge mclk);
    stkRdData <= 8'h0B;
    @(posedge mclk);
    stkRdData <= 8'hCD;
    @(posedge mclk);
    stkRdData <= 8'h32;
    #1;
    chk({pcLoad, pcRestore}, 14'h2BCD, "restored pc");
    chk(flags, 8'h3C, "restored flags");
    chk(opReady, 1'b1, "restore end");
    $display("interrupt done");
  endtask : t_intr

  // ********************************
  // Main sequence and watchdog
  // ********************************
  initial begin
    reset = 1'b1;
    {opValid, regWrEn, regRdEn, brValid, intAck, iretReq} = 6'h00;
    opCode = CSF_OP_LOAD;
    {opA, opB, regAddr, regWrData, opndReg, opndPair} = 48'h0;
    {brOffset, stkRdData, wkNum, daField} = 36'h0;
    {nextPc, pcIn} = 26'h0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    #1;
    t_arith();
    t_logic();
    t_rotate();
    t_regs();
    t_decode();
    t_intr();
    close_out();
  end

  initial begin
    repeat (2000) @(posedge mclk);
    n_fail++;
    close_out();
  end
endmodule : csf_flag_unit_tb
`default_nettype wire
